// *** design/qm_queue_manager.sv ***
// Operation
// R1: Host reads and writes command status register
// R2: Port reads and writes host memory itself
// R3: Bulk data on channel bus only
// R4: Host inserts commands; port removes at head
// R5: Port inserts responses at tail; host removes
// R6: Sixteen protocol free queues plus unknown queue
// R7: Entries drawn from and returned to free queues
// R8: Each entry holds forward and backward links
// R9: Links always address the target forward word
// R10: Port walks queues forward or backward
// R11: Queues reached only through control block headers
// R12: Headers hold only links, no data
// R13: Text data follows command or response part
// R14: Interlock word acquired before any queue change
// R15: Interlock all ones means queue free
// R16: Increment then test; zero means claimed
// R17: Positive after increment: leave links alone
// R18: Interlock honoured by logic, not hardware
// R19: Hold interlock for one insertion or removal
// R20: Release by leaving interlock at minus one
// R21: Base learned from three channel words
// R22: Unknown free queue header at octal ten
// R23: Claim is one locked read-modify-write, retried
`timescale 1ns/100ps
module qm_queue_manager
	import qm_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    rst,
	input  wire logic                    csr_wr,
	input  wire logic                    csr_rd,
	input  wire logic [DW-1:0]           csr_wdata,
	output logic      [DW-1:0]           csr_rdata,
	output logic                         hcb_req,
	output logic                         hcb_we,
	output logic                         hcb_lock,
	output logic      [AW-1:0]           hcb_addr,
	output logic      [DW-1:0]           hcb_wdata,
	input  wire logic                    hcb_ack,
	input  wire logic [DW-1:0]           hcb_rdata,
	output logic                         chn_start,
	output logic      [1:0]              chn_word_cnt,
	input  wire logic                    chn_valid,
	input  wire logic [DW-1:0]           chn_data,
	input  wire logic [QM_NUM_PROTO-1:0] proto_en,
	input  wire logic                    op_valid,
	input  wire logic [1:0]              op_code,
	input  wire logic [4:0]              op_queue,
	input  wire logic [AW-1:0]           op_hdr_addr,
	input  wire logic [AW-1:0]           op_entry,
	input  wire logic                    op_dir_back,
	input  wire logic [7:0]              op_count,
	output logic                         op_ready,
	output logic                         op_done,
	output logic      [2:0]              op_status,
	output logic      [AW-1:0]           op_result,
	output logic      [AW-1:0]           op_data_addr
);

	typedef enum logic [4:0] {
		QM_S_IDLE    = 5'b00000,
		QM_S_CHINIT  = 5'b00001,
		QM_S_LK_RD   = 5'b00010,
		QM_S_LK_WR   = 5'b00011,
		QM_S_RETRY   = 5'b00100,
		QM_S_INS_RB  = 5'b00101,
		QM_S_INS_WF  = 5'b00110,
		QM_S_INS_WB  = 5'b00111,
		QM_S_INS_WP  = 5'b01000,
		QM_S_INS_WH  = 5'b01001,
		QM_S_REM_RF  = 5'b01010,
		QM_S_REM_RN  = 5'b01011,
		QM_S_REM_WH  = 5'b01100,
		QM_S_REM_WN  = 5'b01101,
		QM_S_WALK    = 5'b01110,
		QM_S_UNLOCK  = 5'b01111,
		QM_S_FINISH  = 5'b10000
	} qm_state_t;

	typedef struct packed {
		qm_state_t     st;
		logic          pend;
		logic          mreq;
		logic          mwe;
		logic          mlock;
		logic [AW-1:0] maddr;
		logic [DW-1:0] mwd;
		logic [7:0]    wait_cnt;
		logic [3:0]    tries;
		qm_op_t        code;
		logic [AW-1:0] hdr;
		logic [AW-1:0] entry;
		logic          dir_back;
		logic [7:0]    cnt;
		logic [AW-1:0] a;
		logic [AW-1:0] b;
		logic [1:0]    ch_cnt;
		logic [AW-1:0] base;
		logic [DW-1:0] pia;
		logic          init_done;
		logic          csr_en;
		logic          err;
		logic [DW-1:0] csr_rdata;
		logic          ready;
		logic          done;
		qm_status_t    status;
		logic [AW-1:0] result;
		logic [AW-1:0] data_addr;
		logic          chn_start;
	} qm_main_t;

	qm_main_t q, d;
	qm_mem_if mem ();

	logic [AW-1:0] hdr_flink;
	logic [AW-1:0] rd_link;
	logic [DW-1:0] lock_inc;
	logic          proto_ok;

	qm_mem_access u_mem (
		.core_clk  (core_clk),
		.rst       (rst),
		.m         (mem.acc),
		.hcb_req   (hcb_req),
		.hcb_we    (hcb_we),
		.hcb_lock  (hcb_lock),
		.hcb_addr  (hcb_addr),
		.hcb_wdata (hcb_wdata),
		.hcb_ack   (hcb_ack),
		.hcb_rdata (hcb_rdata)
	);

	assign mem.req   = q.mreq;
	assign mem.we    = q.mwe;
	assign mem.lock  = q.mlock;
	assign mem.addr  = q.maddr;
	assign mem.wdata = q.mwd;

	assign hdr_flink = q.hdr + QM_HDR_FLINK;                      // [R9]
	assign rd_link   = mem.rdata[AW-1:0];
	assign lock_inc  = mem.rdata + {{(DW-1){1'b0}}, 1'b1};        // [R16]
	assign proto_ok  = (op_queue >= QM_Q_PROTO0) && (op_queue <= QM_Q_LAST)
		&& proto_en[4'(op_queue - QM_Q_PROTO0)];                  // [R6]

	always_comb begin
		d = q;
		d.mreq      = 1'b0;
		d.done      = 1'b0;
		d.chn_start = 1'b0;
		if (csr_wr) begin                                        // [R1]
			d.csr_en = csr_wdata[QM_CSR_EN_BIT];
			if (csr_wdata[QM_CSR_INIT_BIT] && q.st == QM_S_IDLE) begin
				d.st        = QM_S_CHINIT;
				d.ready     = 1'b0;
				d.init_done = 1'b0;
				d.ch_cnt    = '0;
				d.chn_start = 1'b1;                              // [R21]
			end
			if (!csr_wdata[QM_CSR_ERR_BIT]) begin
				d.err = 1'b0;
			end
		end
		if (csr_rd) begin                                        // [R1]
			d.csr_rdata = '0;
			d.csr_rdata[QM_CSR_EN_BIT]    = q.csr_en;
			d.csr_rdata[QM_CSR_READY_BIT] = q.init_done;
			d.csr_rdata[QM_CSR_BUSY_BIT]  = (q.st != QM_S_IDLE);
			d.csr_rdata[QM_CSR_ERR_BIT]   = q.err;
		end

		case (q.st)
			QM_S_IDLE: begin
				d.ready = q.init_done && q.csr_en;
				if (op_valid && q.ready) begin
					d.ready    = 1'b0;
					d.code     = qm_op_t'(op_code);
					d.entry    = op_entry;
					d.dir_back = op_dir_back;
					d.cnt      = op_count;
					d.tries    = '0;
					// Every queue is rooted in a control block header
					case (op_queue)                              // [R11]
						QM_Q_CMD: d.hdr = q.base + QM_CMD_HDR_OFS;
						QM_Q_RSP: d.hdr = q.base + QM_RSP_HDR_OFS;
						QM_Q_UNK: d.hdr = q.base + QM_UNK_HDR_OFS; // [R22]
						default:  d.hdr = op_hdr_addr;
					endcase
					if ((op_queue == QM_Q_CMD && op_code == QM_OP_INSERT)    // [R4]
						|| (op_queue == QM_Q_RSP && op_code == QM_OP_REMOVE) // [R5]
						|| (op_queue > QM_Q_UNK && !proto_ok)
						|| op_code == 2'b11) begin
						d.status = QM_ST_REFUSED;
						d.st     = QM_S_FINISH;
					end else begin
						d.st = QM_S_LK_RD;                        // [R14] [R18]
					end
				end
			end
			QM_S_CHINIT: begin
				// Channel carries the three start-up words, the first is the base
				if (chn_valid) begin                             // [R3]
					d.ch_cnt = q.ch_cnt + 2'h1;
					if (q.ch_cnt == 2'h0) begin
						d.base = chn_data[AW-1:0];
					end
					if (q.ch_cnt == 2'h1) begin
						d.pia = chn_data;
					end
					if (q.ch_cnt == QM_INIT_WORDS - 2'h1) begin  // [R21]
						d.init_done = 1'b1;
						d.st        = QM_S_IDLE;
					end
				end
			end
			QM_S_LK_RD: begin
				// Bus lock spans the read and the write-back of the claim
				if (!q.pend) begin
					d.mreq = 1'b1; d.mwe = 1'b0; d.mlock = 1'b1;    // [R23]
					d.maddr = q.hdr; d.pend = 1'b1;
				end else if (mem.done) begin
					d.pend = 1'b0;
					d.st   = QM_S_LK_WR;
				end
			end
			QM_S_LK_WR: begin
				if (!q.pend) begin
					d.mreq = 1'b1; d.mwe = 1'b1; d.mlock = 1'b1;
					d.maddr = q.hdr; d.mwd = lock_inc; d.pend = 1'b1; // [R16]
					d.b = 22'(lock_inc == QM_LOCK_TAKEN);
				end else if (mem.done) begin
					d.pend  = 1'b0;
					d.mlock = 1'b0;
					d.tries = q.tries + 4'h1;
					if (q.b[0]) begin                             // [R15] [R16]
						case (q.code)
							QM_OP_INSERT: d.st = QM_S_INS_RB;
							QM_OP_REMOVE: d.st = QM_S_REM_RF;
							default: begin
								d.st = QM_S_WALK;
								d.a  = hdr_flink;
							end
						endcase
					end else if (q.tries == QM_MAX_TRIES - 4'h1) begin
						// Held elsewhere: nothing is undone and no link touched
						d.status = QM_ST_BUSY;                    // [R17] [R23]
						d.st     = QM_S_FINISH;
					end else begin
						d.wait_cnt = QM_RETRY_CYC;
						d.st       = QM_S_RETRY;
					end
				end
			end
			QM_S_RETRY: begin
				d.wait_cnt = q.wait_cnt - 8'h1;
				if (q.wait_cnt == 8'h1) begin
					d.st = QM_S_LK_RD;                            // [R23]
				end
			end
			QM_S_INS_RB: begin
				if (!q.pend) begin
					d.mreq = 1'b1; d.mwe = 1'b0;
					d.maddr = q.hdr + QM_HDR_BLINK; d.pend = 1'b1;
				end else if (mem.done) begin
					d.pend = 1'b0; d.b = rd_link; d.st = QM_S_INS_WF;
				end
			end
			QM_S_INS_WF: begin
				if (!q.pend) begin
					d.mreq = 1'b1; d.mwe = 1'b1; d.maddr = q.entry;   // [R8]
					d.mwd = DW'(hdr_flink); d.pend = 1'b1;         // [R9]
				end else if (mem.done) begin
					d.pend = 1'b0; d.st = QM_S_INS_WB;
				end
			end
			QM_S_INS_WB: begin
				if (!q.pend) begin
					d.mreq = 1'b1; d.mwe = 1'b1;
					d.maddr = q.entry + QM_ENT_BLINK;             // [R8]
					d.mwd = DW'(q.b); d.pend = 1'b1;
				end else if (mem.done) begin
					d.pend = 1'b0; d.st = QM_S_INS_WP;
				end
			end
			QM_S_INS_WP: begin
				// Old tail's flink (or the header flink when empty) names the entry
				if (!q.pend) begin
					d.mreq = 1'b1; d.mwe = 1'b1; d.maddr = q.b;
					d.mwd = DW'(q.entry); d.pend = 1'b1;          // [R9]
				end else if (mem.done) begin
					d.pend = 1'b0; d.st = QM_S_INS_WH;
				end
			end
			QM_S_INS_WH: begin
				if (!q.pend) begin
					d.mreq = 1'b1; d.mwe = 1'b1;
					d.maddr = q.hdr + QM_HDR_BLINK;               // [R5] [R12]
					d.mwd = DW'(q.entry); d.pend = 1'b1;
				end else if (mem.done) begin
					d.pend = 1'b0; d.status = QM_ST_OK;
					d.a = q.entry; d.st = QM_S_UNLOCK;
				end
			end
			QM_S_REM_RF: begin
				if (!q.pend) begin
					d.mreq = 1'b1; d.mwe = 1'b0; d.maddr = hdr_flink; // [R4]
					d.pend = 1'b1;
				end else if (mem.done) begin
					d.pend = 1'b0; d.a = rd_link;
					if (rd_link == hdr_flink) begin
						d.status = QM_ST_EMPTY;
						d.st     = QM_S_UNLOCK;
					end else begin
						d.st = QM_S_REM_RN;
					end
				end
			end
			QM_S_REM_RN: begin
				if (!q.pend) begin
					d.mreq = 1'b1; d.mwe = 1'b0; d.maddr = q.a; d.pend = 1'b1;
				end else if (mem.done) begin
					d.pend = 1'b0; d.b = rd_link; d.st = QM_S_REM_WH;
				end
			end
			QM_S_REM_WH: begin
				if (!q.pend) begin
					d.mreq = 1'b1; d.mwe = 1'b1; d.maddr = hdr_flink;
					d.mwd = DW'(q.b); d.pend = 1'b1;
				end else if (mem.done) begin
					d.pend = 1'b0; d.st = QM_S_REM_WN;
				end
			end
			QM_S_REM_WN: begin
				if (!q.pend) begin
					d.mreq = 1'b1; d.mwe = 1'b1; d.maddr = q.b + QM_ENT_BLINK;
					d.mwd = DW'(hdr_flink); d.pend = 1'b1;        // [R9]
				end else if (mem.done) begin
					d.pend = 1'b0; d.status = QM_ST_OK; d.st = QM_S_UNLOCK; // [R7]
				end
			end
			QM_S_WALK: begin
				if (q.cnt == 8'h0) begin
					d.status = QM_ST_OK; d.st = QM_S_UNLOCK;
				end else if (!q.pend) begin
					d.mreq = 1'b1; d.mwe = 1'b0; d.pend = 1'b1;   // [R10]
					d.maddr = q.dir_back ? q.a + QM_ENT_BLINK : q.a;
				end else if (mem.done) begin
					d.pend = 1'b0; d.a = rd_link; d.cnt = q.cnt - 8'h1;
					if (rd_link == hdr_flink) begin
						d.status = QM_ST_NOTFOUND; d.st = QM_S_UNLOCK;
					end
				end
			end
			QM_S_UNLOCK: begin
				// Released straight after one change, never held across ops
				if (!q.pend) begin
					d.mreq = 1'b1; d.mwe = 1'b1; d.maddr = q.hdr;     // [R19]
					d.mwd = QM_LOCK_FREE; d.pend = 1'b1;           // [R20]
				end else if (mem.done) begin
					d.pend = 1'b0; d.st = QM_S_FINISH;
				end
			end
			QM_S_FINISH: begin
				d.done      = 1'b1;
				d.result    = q.a;
				d.data_addr = q.a + QM_ENT_DATA_OFS;              // [R13]
				d.err       = q.err | (q.status != QM_ST_OK);
				d.st        = QM_S_IDLE;
			end
			default: d.st = QM_S_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin                        // [R2]
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign csr_rdata    = q.csr_rdata;
	assign chn_start    = q.chn_start;
	assign chn_word_cnt = QM_INIT_WORDS;
	assign op_ready     = q.ready;
	assign op_done      = q.done;
	assign op_status    = q.status;
	assign op_result    = q.result;
	assign op_data_addr = q.data_addr;

endmodule

// *** design/qm_pkg.sv ***
package qm_pkg;

	localparam int DW = 36;
	localparam int AW = 22;

	localparam logic [DW-1:0] QM_LOCK_FREE  = {DW{1'b1}};
	localparam logic [DW-1:0] QM_LOCK_TAKEN = '0;

	// Header offsets within the port control block, then header and entry word offsets
	localparam logic [AW-1:0] QM_CMD_HDR_OFS  = 22'h0;
	localparam logic [AW-1:0] QM_RSP_HDR_OFS  = 22'h4;
	localparam logic [AW-1:0] QM_UNK_HDR_OFS  = 22'h8;
	localparam logic [AW-1:0] QM_HDR_FLINK    = 22'h1;
	localparam logic [AW-1:0] QM_HDR_BLINK    = 22'h2;
	localparam logic [AW-1:0] QM_ENT_BLINK    = 22'h1;
	localparam logic [AW-1:0] QM_ENT_DATA_OFS = 22'h3;

	// Initial channel fetch: three words from control block word 24 octal
	localparam logic [AW-1:0] QM_INIT_WORD_OFS = 22'h14;
	localparam logic [1:0]    QM_INIT_WORDS    = 2'h3;

	localparam int              QM_NUM_PROTO    = 16;
	localparam logic [4:0]      QM_Q_CMD        = 5'h0;
	localparam logic [4:0]      QM_Q_RSP        = 5'h1;
	localparam logic [4:0]      QM_Q_UNK        = 5'h2;
	localparam logic [4:0]      QM_Q_PROTO0     = 5'h3;
	localparam logic [4:0]      QM_Q_LAST       = 5'h12;

	localparam int              QM_CLK_MHZ      = 40;
	localparam int              QM_RETRY_NS     = 1000;
	localparam int              QM_RETRY_CYC_I  = (QM_RETRY_NS * QM_CLK_MHZ) / 1000;
	localparam logic [7:0]      QM_RETRY_CYC    = QM_RETRY_CYC_I[7:0];
	localparam logic [3:0]      QM_MAX_TRIES    = 4'h8;

	// Command and status register fields
	localparam int QM_CSR_EN_BIT    = 0;
	localparam int QM_CSR_INIT_BIT  = 1;
	localparam int QM_CSR_READY_BIT = 2;
	localparam int QM_CSR_BUSY_BIT  = 3;
	localparam int QM_CSR_ERR_BIT   = 4;

	typedef enum logic [1:0] {
		QM_OP_INSERT = 2'b00,
		QM_OP_REMOVE = 2'b01,
		QM_OP_WALK   = 2'b10
	} qm_op_t;

	typedef enum logic [2:0] {
		QM_ST_OK       = 3'b000,
		QM_ST_EMPTY    = 3'b001,
		QM_ST_BUSY     = 3'b010,
		QM_ST_NOTFOUND = 3'b011,
		QM_ST_REFUSED  = 3'b100
	} qm_status_t;

endpackage

// *** design/qm_mem_if.sv ***
`timescale 1ns/100ps
interface qm_mem_if;
	import qm_pkg::*;
	logic          req;
	logic          we;
	logic          lock;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic          done;
	logic [DW-1:0] rdata;

	modport ctl (output req, we, lock, addr, wdata, input done, rdata);
	modport acc (input req, we, lock, addr, wdata, output done, rdata);
endinterface

// *** design/qm_mem_access.sv ***
`timescale 1ns/100ps
module qm_mem_access
	import qm_pkg::*;
(
	input  wire logic          core_clk,
	input  wire logic          rst,
	qm_mem_if.acc              m,
	output logic               hcb_req,
	output logic               hcb_we,
	output logic               hcb_lock,
	output logic [AW-1:0]      hcb_addr,
	output logic [DW-1:0]      hcb_wdata,
	input  wire logic          hcb_ack,
	input  wire logic [DW-1:0] hcb_rdata
);

	typedef struct packed {
		logic          req;
		logic          we;
		logic          lock;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic          done;
		logic [DW-1:0] rdata;
	} qm_acc_t;

	qm_acc_t q, d;

	always_comb begin
		d = q;
		d.done = 1'b0;
		if (!q.req && m.req) begin
			d.req   = 1'b1;
			d.we    = m.we;
			d.lock  = m.lock;
			d.addr  = m.addr;
			d.wdata = m.wdata;
		end else if (q.req && hcb_ack) begin
			d.req  = 1'b0;
			d.done = 1'b1;
			// Lock falls with the claim's write-back, not a cycle later
			d.lock = m.lock && !q.we;
			if (!q.we) begin
				d.rdata = hcb_rdata;
			end
		end else if (!q.req) begin
			// Lock stays up between the read and write halves of a claim
			d.lock = m.lock && !(q.done && q.we);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign hcb_req   = q.req;
	assign hcb_we    = q.we;
	assign hcb_lock  = q.lock;
	assign hcb_addr  = q.addr;
	assign hcb_wdata = q.wdata;
	assign m.done    = q.done;
	assign m.rdata   = q.rdata;

endmodule

// *** verif/qm_host_mem.sv ***
`timescale 1ns/100ps
module qm_host_mem
	import qm_pkg::*;
#(
	parameter logic [AW-1:0] BASE = 22'h2000
) (
	input  wire logic          core_clk,
	input  wire logic          hcb_req,
	input  wire logic          hcb_we,
	input  wire logic [AW-1:0] hcb_addr,
	input  wire logic [DW-1:0] hcb_wdata,
	output logic               hcb_ack,
	output logic [DW-1:0]      hcb_rdata,
	input  wire logic          chn_start,
	output logic               chn_valid,
	output logic [DW-1:0]      chn_data,
	input  wire logic [1:0]    slow
);
	logic [DW-1:0] mem [int];
	int            wait_n;
	int            chn_n;

	// Empty header: links point back at its own forward word, no data area
	task automatic hdr_init(logic [AW-1:0] h);
		mem[h] = QM_LOCK_FREE;
		mem[h + 1] = DW'(h + 1);
		mem[h + 2] = DW'(h + 1);
	endtask

	initial begin
		hcb_ack = 1'b0;
		hcb_rdata = '0;
		chn_valid = 1'b0;
		chn_data = '0;
		wait_n = 0;
		chn_n = 0;
	end

	// Idle data lines toggle so a stale capture cannot pass for a real one
	always @(posedge core_clk) begin
		hcb_ack <= 1'b0;
		hcb_rdata <= ~hcb_rdata;
		if (hcb_req && !hcb_ack) begin
			if (wait_n < slow) begin
				wait_n <= wait_n + 1;
			end else begin
				wait_n <= 0;
				hcb_ack <= 1'b1;
				if (hcb_we) begin
					mem[hcb_addr] = hcb_wdata;
				end else begin
					hcb_rdata <= mem.exists(hcb_addr) ? mem[hcb_addr] : '0;
				end
			end
		end
	end

	// Three channel words: control block base, interrupt assignment, reserved
	always @(posedge core_clk) begin
		chn_valid <= 1'b0;
		if (chn_start) begin
			chn_n <= 3;
		end else if (chn_n != 0) begin
			chn_valid <= 1'b1;
			chn_data <= (chn_n == 3) ? DW'(BASE) : DW'(chn_n);
			chn_n <= chn_n - 1;
		end else begin
			chn_data <= ~chn_data;
		end
	end
endmodule

// *** verif/qm_queue_manager_sva.sv ***
`timescale 1ns/100ps
module qm_queue_manager_sva
	import qm_pkg::*;
(
	input wire logic                    core_clk,
	input wire logic                    rst,
	input wire logic                    hcb_req,
	input wire logic                    hcb_we,
	input wire logic                    hcb_lock,
	input wire logic [AW-1:0]           hcb_addr,
	input wire logic [DW-1:0]           hcb_wdata,
	input wire logic                    hcb_ack,
	input wire logic [DW-1:0]           hcb_rdata,
	input wire logic                    chn_start,
	input wire logic [1:0]              chn_word_cnt,
	input wire logic [QM_NUM_PROTO-1:0] proto_en,
	input wire logic                    op_valid,
	input wire logic                    op_ready,
	input wire logic [1:0]              op_code,
	input wire logic [4:0]              op_queue,
	input wire logic                    op_done,
	input wire logic [2:0]              op_status,
	input wire logic [AW-1:0]           op_result,
	input wire logic [AW-1:0]           op_data_addr
);
	logic [DW-1:0] claim_rd_q;

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			claim_rd_q <= '0;
		end else if (hcb_lock && hcb_req && !hcb_we && hcb_ack) begin
			claim_rd_q <= hcb_rdata;
		end
	end

	req_hold_a: assert property (hcb_req && !hcb_ack |=> hcb_req && $stable(hcb_addr)
		&& $stable(hcb_we) && $stable(hcb_wdata)) else $error("bus request changed early");
	ack_ends_a: assert property (hcb_req && hcb_ack |=> !hcb_req)
		else $error("bus request outlived its ack");
	claim_read_a: assert property ($rose(hcb_lock) |-> hcb_req && !hcb_we)
		else $error("claim did not start with a read");
	claim_incr_a: assert property (hcb_lock && hcb_req && hcb_we
		|-> hcb_wdata == claim_rd_q + 1'b1) else $error("claim write is not old value plus one");
	lock_drop_a: assert property (hcb_lock && hcb_req && hcb_we && hcb_ack
		|-> ##[1:2] !hcb_lock) else $error("bus lock held past claim write");
	held_off_a: assert property (hcb_lock && hcb_we && hcb_ack && hcb_wdata != '0
		|=> !hcb_req [*8]) else $error("links touched after failed claim");
	chn_count_a: assert property (chn_word_cnt == 2'h3 and (chn_start |=> !chn_start))
		else $error("channel start malformed");
	data_addr_a: assert property (op_done |-> op_data_addr == op_result + 22'h3)
		else $error("data address not after link words");
	done_ready_a: assert property (op_done |=> !op_done && op_ready)
		else $error("op done not followed by ready");
	take_drop_a: assert property (op_valid && op_ready |=> !op_ready)
		else $error("ready stayed high after take");
	off_queue_a: assert property (op_valid && op_ready && op_queue >= QM_Q_PROTO0
		&& op_queue <= QM_Q_LAST && !proto_en[op_queue - QM_Q_PROTO0]
		|=> !hcb_req throughout (##[0:4] op_done)) else $error("disabled queue was accessed");

	cover property (op_done && op_status == 3'h0);
	cover property (op_done && op_status == 3'h2);
	cover property (op_done && op_status == 3'h4);
endmodule

bind qm_queue_manager qm_queue_manager_sva u_sva (.core_clk(core_clk), .rst(rst),
	.hcb_req(hcb_req), .hcb_we(hcb_we), .hcb_lock(hcb_lock), .hcb_addr(hcb_addr),
	.hcb_wdata(hcb_wdata), .hcb_ack(hcb_ack), .hcb_rdata(hcb_rdata), .chn_start(chn_start),
	.chn_word_cnt(chn_word_cnt), .proto_en(proto_en), .op_valid(op_valid),
	.op_ready(op_ready), .op_code(op_code), .op_queue(op_queue), .op_done(op_done),
	.op_status(op_status), .op_result(op_result), .op_data_addr(op_data_addr));

// *** verif/host_memory_queue_manager_test.sv ***
`timescale 1ns/100ps
module host_memory_queue_manager_test;
	import qm_pkg::*;
	localparam logic [AW-1:0] BASE = 22'h2000;
	localparam logic [AW-1:0] PHDR = 22'h3000;
	logic                    core_clk, rst, csr_wr, csr_rd, hcb_req, hcb_we, hcb_lock, hcb_ack;
	logic [DW-1:0]           csr_wdata, csr_rdata, hcb_wdata, hcb_rdata, chn_data;
	logic                    chn_start, chn_valid, op_valid, op_dir_back, op_ready, op_done;
	logic [AW-1:0]           hcb_addr, op_hdr_addr, op_entry, op_result, op_data_addr, hu, e;
	logic [1:0]              chn_word_cnt, op_code, slow;
	logic [QM_NUM_PROTO-1:0] proto_en;
	logic [4:0]              op_queue;
	logic [7:0]              op_count;
	logic [2:0]              op_status;
	logic [6:0]              rf [4];
	logic [AW-1:0]           ref_q [$];
	int                      error_cnt, checks, seed, k;

	qm_queue_manager uut (.core_clk, .rst, .csr_wr, .csr_rd, .csr_wdata, .csr_rdata, .hcb_req,
		.hcb_we, .hcb_lock, .hcb_addr, .hcb_wdata, .hcb_ack, .hcb_rdata, .chn_start,
		.chn_word_cnt, .chn_valid, .chn_data, .proto_en, .op_valid, .op_code, .op_queue,
		.op_hdr_addr, .op_entry, .op_dir_back, .op_count, .op_ready, .op_done, .op_status,
		.op_result, .op_data_addr);
	qm_host_mem #(.BASE(BASE)) mem_u (.core_clk, .hcb_req, .hcb_we, .hcb_addr, .hcb_wdata,
		.hcb_ack, .hcb_rdata, .chn_start, .chn_valid, .chn_data, .slow);

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic cmp_stat(string what, logic [2:0] exp, logic [2:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic cmp_val(string what, logic [DW-1:0] exp, logic [DW-1:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Called just after an edge; memory latency is reshuffled for each operation
	task automatic run_op(logic [1:0] c, logic [4:0] q, logic [AW-1:0] h, logic [AW-1:0] en,
		logic b, logic [7:0] n);
		slow = 2'($random(seed));
		op_code = c;
		op_queue = q;
		op_hdr_addr = h;
		op_entry = en;
		op_dir_back = b;
		op_count = n;
		op_valid = 1'b1;
		for (int i = 0; i < 100 && op_ready !== 1'b1; i++) @(posedge core_clk) #2;
		@(posedge core_clk) #2;
		op_valid = 1'b0;
		for (int i = 0; i < 2000 && op_done !== 1'b1; i++) @(posedge core_clk) #2;
		if (op_done !== 1'b1) begin
			error_cnt++;
			$display("BAD op_done expected 1 seen %b", op_done);
		end
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		seed = 32'h9fbc67c3;
		{rst, csr_wr, csr_rd, csr_wdata, proto_en, op_valid, op_code, op_queue} = '0;
		{op_hdr_addr, op_entry, op_dir_back, op_count, slow} = '0;
		rst = 1'b1;
		error_cnt = 0;
		checks = 0;
		hu = BASE + QM_UNK_HDR_OFS;
		mem_u.hdr_init(BASE);
		mem_u.hdr_init(BASE + QM_RSP_HDR_OFS);
		mem_u.hdr_init(hu);
		mem_u.hdr_init(PHDR);
		repeat (12) @(posedge core_clk);
		#2 rst = 1'b0;
		csr_wdata = 36'h3;
		csr_wr = 1'b1;
		@(posedge core_clk) #2 csr_wr = 1'b0;
		for (int i = 0; i < 50 && op_ready !== 1'b1; i++) @(posedge core_clk) #2;
		csr_rd = 1'b1;
		@(posedge core_clk) #2 csr_rd = 1'b0;
		@(posedge core_clk) #2;
		cmp_val("csr", DW'(5'b00101), DW'(csr_rdata[4:0]));
		for (k = 0; k < 3; k++) begin
			e = 22'h1000 + 22'(k * 8) + 22'($random(seed) & 3);
			run_op(2'h0, QM_Q_UNK, '0, e, 1'b0, 8'h0);
			ref_q.push_back(e);
			cmp_stat("insert", QM_ST_OK, op_status);
			cmp_val("insert", DW'(e), DW'(op_result));
		end
		cmp_val("head", DW'(ref_q[0]), mem_u.mem[hu + 1]);
		cmp_val("tail", DW'(ref_q[2]), mem_u.mem[hu + 2]);
		cmp_val("back", DW'(hu + 1), mem_u.mem[ref_q[0] + 1]);
		cmp_val("lock", QM_LOCK_FREE, mem_u.mem[hu]);
		run_op(2'h2, QM_Q_UNK, '0, '0, 1'b0, 8'd2);
		cmp_val("walk fwd", DW'(ref_q[1]), DW'(op_result));
		run_op(2'h2, QM_Q_UNK, '0, '0, 1'b1, 8'd1);
		cmp_val("walk back", DW'(ref_q[2]), DW'(op_result));
		run_op(2'h2, QM_Q_UNK, '0, '0, 1'b0, 8'd4);
		cmp_stat("walk end", QM_ST_NOTFOUND, op_status);
		for (k = 0; k < 4; k++) begin
			run_op(2'h1, QM_Q_UNK, '0, '0, 1'b0, 8'h0);
			if (ref_q.size() == 0) begin
				cmp_stat("remove", QM_ST_EMPTY, op_status);
			end else begin
				cmp_stat("remove", QM_ST_OK, op_status);
				cmp_val("remove", DW'(ref_q.pop_front()), DW'(op_result));
			end
		end
		// Host side links one command the way the driver would
		mem_u.mem[BASE + 1] = DW'(22'h1700);
		mem_u.mem[BASE + 2] = DW'(22'h1700);
		mem_u.mem[22'h1700] = DW'(BASE + 1);
		mem_u.mem[22'h1701] = DW'(BASE + 1);
		run_op(2'h1, QM_Q_CMD, '0, '0, 1'b0, 8'h0);
		cmp_val("command", DW'(22'h1700), DW'(op_result));
		cmp_val("cmd head", DW'(BASE + 1), mem_u.mem[BASE + 1]);
		run_op(2'h0, QM_Q_RSP, '0, 22'h1800, 1'b0, 8'h0);
		cmp_val("rsp tail", DW'(22'h1800), mem_u.mem[BASE + QM_RSP_HDR_OFS + 2]);
		k = $random(seed) & 15;
		proto_en = QM_NUM_PROTO'(1) << k;
		run_op(2'h0, QM_Q_PROTO0 + 5'(k), PHDR, 22'h1900, 1'b0, 8'h0);
		run_op(2'h1, QM_Q_PROTO0 + 5'(k), PHDR, '0, 1'b0, 8'h0);
		cmp_val("proto", DW'(22'h1900), DW'(op_result));
		rf = '{{2'h0, QM_Q_CMD}, {2'h1, QM_Q_RSP}, {2'h3, QM_Q_UNK},
			{2'h0, QM_Q_PROTO0 + 5'((k + 1) % 16)}};
		foreach (rf[i]) begin
			run_op(rf[i][6:5], rf[i][4:0], PHDR, 22'h1a00, 1'b0, 8'h0);
			cmp_stat("refuse", QM_ST_REFUSED, op_status);
		end
		mem_u.mem[hu] = '0;
		run_op(2'h0, QM_Q_UNK, '0, 22'h1a00, 1'b0, 8'h0);
		cmp_stat("busy", QM_ST_BUSY, op_status);
		cmp_val("interlock", DW'(8), mem_u.mem[hu]);
		csr_rd = 1'b1;
		@(posedge core_clk) #2 csr_rd = 1'b0;
		cmp_val("csr err", DW'(5'b10101), DW'(csr_rdata[4:0]));
		tally_and_finish();
	end
endmodule
